// ### src/art_timer.sv
/*
  16-bit auto-reload up-counting timer with reload register, control byte,
  toggling output and a sticky overflow interrupt.
  assumes a single clock, a register port whose strobes never coincide and a
  prescaled base clock arriving as a pin from outside this domain.
*/
`timescale 1ns/1ps
`default_nettype none
module art_timer
  import art_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  // prescaled base clock pin
  input wire logic base_clock_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [15:0] rdata_o,
  // timer output and interrupt
  output logic timer_out_o,
  output logic irq_o
);

  // state
  logic [15:0] count_r; // counter, no reset value
  logic [15:0] reload_r; // reload, no reset value
  logic [7:0] control_r; // control byte
  logic status_r; // sticky overflow request flag
  logic irq_en_r; // enable of that flag
  logic count_known_r; // counter written since reset, read by checks only
  logic [15:0] count_nxt;
  logic [15:0] reload_nxt;
  logic [7:0] control_nxt;
  logic status_nxt;
  logic [15:0] rdata_nxt;

  // decodes
  logic base_tick;
  logic count_tick;
  logic overflow;
  logic wr_count;
  logic wr_reload;
  logic wr_control;
  logic wr_clear;
  logic wr_enable;
  logic [7:0] control_w; // masked write value

  // address match shared by write and read decodes
  function automatic logic hit_at(input logic [7:0] a, input logic [7:0] off);
    hit_at = (a == off);
  endfunction

  // control byte with its output bit inverted, shared by write and hold paths
  function automatic logic [7:0] flip_out(input logic [7:0] c);
    flip_out = c ^ (8'h1 << ART_CTL_OUT);
  endfunction

  // synchronise the base clock into a tick
  art_sync3 u_sync
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(enable_i),
    .pin_i(base_clock_i),
    .rise_o(base_tick)
  );

  // divide base tick per select code into the count clock
  art_clock_select u_sel
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(enable_i),
    .select_i(control_r[2:0]),
    .run_i(control_r[ART_CTL_RUN]),
    .base_tick_i(base_tick),
    .count_tick_o(count_tick)
  );

  // write decodes
  assign wr_count = write_i && hit_at(addr_i, ART_OFF_COUNT);
  assign wr_reload = write_i && hit_at(addr_i, ART_OFF_RELOAD);
  assign wr_control = write_i && hit_at(addr_i, ART_OFF_CONTROL);
  assign wr_clear = write_i && hit_at(addr_i, ART_OFF_IRQ_CLEAR);
  assign wr_enable = write_i && hit_at(addr_i, ART_OFF_IRQ_ENABLE);

  // overflow when the counter steps past all ones while running
  assign overflow = count_tick && control_r[ART_CTL_RUN]
                    && (count_r == ART_COUNT_MAX);

  // counter: write wins, then reload on overflow, then step
  // a tick still in flight when run drops is ignored, so a stop is immediate
  assign count_nxt = wr_count ? wdata_i
                   : overflow ? reload_r
                   : (count_tick && control_r[ART_CTL_RUN]) ? 16'(count_r + 16'h1)
                   : count_r;

  // counter writes copy into reload as well
  assign reload_nxt = (wr_count || wr_reload) ? wdata_i : reload_r;

  // bits 4..6 forced one; bit 7 inverts on overflow
  assign control_w = (wdata_i[7:0] & ART_CTL_WMASK) | ART_CTL_FIXED_ONES;
  assign control_nxt = wr_control
                       ? (overflow ? flip_out(control_w) : control_w)
                       : (overflow ? flip_out(control_r) : control_r);

  // sticky flag: overflow beats a simultaneous clear
  assign status_nxt = overflow || (status_r && !(wr_clear && wdata_i[ART_IRQ_OVF]));

  // read mux, unmapped reads zero
  assign rdata_nxt = hit_at(addr_i, ART_OFF_COUNT) ? count_r
                   : hit_at(addr_i, ART_OFF_RELOAD) ? reload_r
                   : hit_at(addr_i, ART_OFF_CONTROL) ? {8'h0, control_r}
                   : hit_at(addr_i, ART_OFF_IRQ_STATUS) ? {15'h0, status_r}
                   : hit_at(addr_i, ART_OFF_IRQ_ENABLE) ? {15'h0, irq_en_r}
                   : 16'h0;

  // counter and reload carry no reset: their content is undefined
  always_ff @(posedge clock_i)
  begin
    if (enable_i)
    begin
      count_r <= count_nxt;
      reload_r <= reload_nxt;
    end
  end

  // set by the first counter write; keeps checks off the undefined start
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      count_known_r <= 1'b0;
    else if (enable_i && wr_count)
      count_known_r <= 1'b1;
  end

  // control, interrupt and outputs
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      control_r <= ART_CTL_RESET;
      status_r <= 1'b0;
      irq_en_r <= 1'b0;
      rdata_o <= 16'h0;
      timer_out_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else if (enable_i)
    begin
      control_r <= control_nxt;
      status_r <= status_nxt;
      if (wr_enable)
        irq_en_r <= wdata_i[ART_IRQ_OVF];
      // read data valid the cycle after the strobe only
      rdata_o <= read_i ? rdata_nxt : 16'h0;
      timer_out_o <= control_nxt[ART_CTL_OUT];
      irq_o <= status_nxt && (wr_enable ? wdata_i[ART_IRQ_OVF] : irq_en_r);
    end
  end

  // the control register reads its fixed ones at all times
  property p_ctl_ones;
    @(posedge clock_i) disable iff (!resetn_i)
    (control_r & ART_CTL_FIXED_ONES) == ART_CTL_FIXED_ONES;
  endproperty
  a_ctl_ones: assert property (p_ctl_ones) else $error("control bits 4-6 not one");

  // overflow reloads the counter
  property p_reload;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && overflow && !wr_count) |=> count_r == $past(reload_r);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on overflow");

  // overflow toggles output bit
  property p_toggle;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && overflow && !wr_control) |=> control_r[ART_CTL_OUT] != $past(control_r[ART_CTL_OUT]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("output not inverted");

  // counter write copies into reload
  property p_copy;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && wr_count) |=> (reload_r == $past(wdata_i)) && (count_r == reload_r);
  endproperty
  a_copy: assert property (p_copy) else $error("counter write missed reload");

  // stopped timer holds its count
  property p_halt;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && count_known_r && !control_r[ART_CTL_RUN] && !write_i) |=> count_r == $past(count_r);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved while stopped");

  // a running tick below the top adds exactly one
  property p_step;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && count_known_r && control_r[ART_CTL_RUN] && count_tick && !overflow && !wr_count)
      |=> count_r == 16'($past(count_r) + 16'h1);
  endproperty
  a_step: assert property (p_step) else $error("count did not step");

  // only a selected count tick moves the counter
  property p_no_tick;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && count_known_r && !count_tick && !wr_count) |=> count_r == $past(count_r);
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("count moved without tick");

  // reload holds unless written
  property p_reload_hold;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && count_known_r && !wr_count && !wr_reload) |=> reload_r == $past(reload_r);
  endproperty
  a_reload_hold: assert property (p_reload_hold) else $error("reload changed unwritten");

  // control write keeps bits 4-6 at one
  property p_ctl_write;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && wr_control && !overflow)
      |=> control_r == ((8'($past(wdata_i)) & ART_CTL_WMASK) | ART_CTL_FIXED_ONES);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write wrong");

  // output pin follows control bit 7
  property p_out_level;
    @(posedge clock_i) disable iff (!resetn_i)
    enable_i |=> timer_out_o == control_r[ART_CTL_OUT];
  endproperty
  a_out_level: assert property (p_out_level) else $error("output level differs from bit 7");

  // reset values of control, flag, enable, both outputs and read data
  property p_reset_vals;
    @(posedge clock_i)
    !resetn_i |=> (control_r == ART_CTL_RESET) && !status_r && !irq_en_r
                  && !timer_out_o && !irq_o && (rdata_o == 16'h0);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  // no count tick once run is clear
  property p_tick_stop;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && !control_r[ART_CTL_RUN]) |=> !count_tick;
  endproperty
  a_tick_stop: assert property (p_tick_stop) else $error("tick while stopped");

  // read data zero outside the read answer cycle
  property p_rdata_idle;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && !read_i) |=> rdata_o == 16'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  // counter read returns the counter
  property p_rdata_count;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && count_known_r && read_i && hit_at(addr_i, ART_OFF_COUNT)) |=> rdata_o == $past(count_r);
  endproperty
  a_rdata_count: assert property (p_rdata_count) else $error("counter read wrong");

  // reload read returns the reload register
  property p_rdata_reload;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && count_known_r && read_i && hit_at(addr_i, ART_OFF_RELOAD)) |=> rdata_o == $past(reload_r);
  endproperty
  a_rdata_reload: assert property (p_rdata_reload) else $error("reload read wrong");

  // control read returns the byte in the low half
  property p_rdata_ctl;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && read_i && hit_at(addr_i, ART_OFF_CONTROL)) |=> rdata_o == {8'h0, $past(control_r)};
  endproperty
  a_rdata_ctl: assert property (p_rdata_ctl) else $error("control read wrong");

  // status read returns the flag
  property p_rdata_status;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && read_i && hit_at(addr_i, ART_OFF_IRQ_STATUS)) |=> rdata_o == {15'h0, $past(status_r)};
  endproperty
  a_rdata_status: assert property (p_rdata_status) else $error("status read wrong");

  // clear with no overflow empties the flag
  property p_clear;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && wr_clear && wdata_i[ART_IRQ_OVF] && !overflow) |=> !status_r;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  // flag stays until cleared
  property p_sticky;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && status_r && !wr_clear) |=> status_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

  // disabled flag never reaches the pin
  property p_irq_masked;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && !irq_en_r && !wr_enable) |=> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while disabled");

  // enable register write stores bit 0
  property p_en_write;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && wr_enable) |=> irq_en_r == $past(wdata_i[ART_IRQ_OVF]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");

  // clock enable low freezes state
  property p_freeze;
    @(posedge clock_i) disable iff (!resetn_i)
    (resetn_i && !enable_i) |=> (control_r == $past(control_r)) && (status_r == $past(status_r))
                                && (rdata_o == $past(rdata_o));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // overflow sets flag
  property p_flag;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && overflow) |=> status_r;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");

  // interrupt follows flag and enable
  property p_irq;
    @(posedge clock_i) disable iff (!resetn_i)
    enable_i |=> irq_o == (status_r && irq_en_r);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  // invalid clock code never counts
  property p_invalid;
    @(posedge clock_i) disable iff (!resetn_i)
    (control_r[2:0] == ART_CS_INVALID) [*2] |-> !count_tick;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid select counted");

  // reload register write stores
  property p_reload_wr;
    @(posedge clock_i) disable iff (!resetn_i)
    (enable_i && wr_reload) |=> reload_r == $past(wdata_i);
  endproperty
  a_reload_wr: assert property (p_reload_wr) else $error("reload write lost");

endmodule
`default_nettype wire

// ### src/art_pkg.sv
/*
  package of the 16-bit auto-reload timer: register offsets, field positions,
  reset values, clock-select codes and interrupt layout.
  assumes a byte-addressed register port with 16-bit data.
*/
// Summary of operation
// - 16-bit up-counter, overflow reloads and requests interrupt
// - counter and reload undefined after reset
// - counter write also writes reload register
// - reload register 16 bits, read/write
// - low three control bits pick count clock
// - control bit 3 runs or halts counting
// - bit 7 sets output level, toggles on overflow
// - control bits 4 to 6 read one
// - system reset sets control to 70H
// - overflow sets request flag, enable gates delivery
// - count clocks derive from prescaled base clock
package art_pkg;

  // register offsets
  localparam logic [7:0] ART_OFF_COUNT = 8'h62;
  localparam logic [7:0] ART_OFF_RELOAD = 8'h64;
  localparam logic [7:0] ART_OFF_CONTROL = 8'h66;
  localparam logic [7:0] ART_OFF_IRQ_STATUS = 8'h68;
  localparam logic [7:0] ART_OFF_IRQ_CLEAR = 8'h6A;
  localparam logic [7:0] ART_OFF_IRQ_ENABLE = 8'h6C;

  // control field positions and values
  localparam int ART_CTL_RUN = 3;
  localparam int ART_CTL_OUT = 7;
  localparam logic [7:0] ART_CTL_RESET = 8'h70;
  localparam logic [7:0] ART_CTL_FIXED_ONES = 8'h70;
  localparam logic [7:0] ART_CTL_WMASK = 8'h8F;

  // clock-select codes
  localparam logic [2:0] ART_CS_INVALID = 3'h7;
  localparam logic [3:0] ART_DIV_LOG_MAX = 4'h6;

  // interrupt status layout, one event
  localparam int ART_IRQ_OVF = 0;

  // datapath widths
  localparam int ART_WIDTH = 16;
  localparam logic [15:0] ART_COUNT_MAX = 16'hFFFF;

endpackage

// ### src/art_clock_select.sv
/*
  count-clock select: turns the prescaled base clock tick into a one-cycle
  count enable divided by 1,2,4,...,64 per the three-bit code.
  assumes base_tick_i is a one-cycle pulse on clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module art_clock_select
  import art_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  // control
  input wire logic [2:0] select_i,
  input wire logic run_i,
  input wire logic base_tick_i,
  // count enable
  output logic count_tick_o
);

  logic [5:0] div_r; // free divider of base ticks
  logic [5:0] div_nxt;
  logic [5:0] mask; // low bits that must be all ones
  logic hit;

  // divider is mask of 2^code - 1; invalid code never ticks
  assign mask = 6'(({6'h0, 1'b1} << select_i) - 7'h1);
  assign hit = base_tick_i && run_i && (select_i != ART_CS_INVALID)
               && ((div_r & mask) == mask);
  assign div_nxt = run_i ? 6'(div_r + 6'h1) : 6'h0;

  // advance only on base ticks, cleared while stopped
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      div_r <= 6'h0;
      count_tick_o <= 1'b0;
    end
    else if (enable_i)
    begin
      if (base_tick_i || !run_i)
        div_r <= div_nxt;
      count_tick_o <= hit;
    end
  end

endmodule
`default_nettype wire

// ### src/art_sync3.sv
/*
  three-stage synchroniser for the prescaled base clock pin, emitting a
  one-cycle pulse per rising edge once stages two and three agree.
  assumes the pin toggles slower than clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module art_sync3
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  // pin and pulse
  input wire logic pin_i,
  output logic rise_o
);

  logic [2:0] sync_r; // stage 0 read only by stage 1
  logic level_r; // filtered level

  // settled level changes only when stages 1 and 2 agree
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      sync_r <= 3'h0;
      level_r <= 1'b0;
      rise_o <= 1'b0;
    end
    else if (enable_i)
    begin
      sync_r <= {sync_r[1:0], pin_i};
      if (sync_r[1] == sync_r[2])
        level_r <= sync_r[2];
      rise_o <= (sync_r[1] == sync_r[2]) && sync_r[2] && !level_r;
    end
  end

endmodule
`default_nettype wire

// ### sim/tb_art_timer.sv
/*
  self-checking bench for the 16-bit auto-reload timer: register access,
  counting per clock select, overflow reload, output toggle and interrupt.
  assumes the register port and base clock pin are driven from here alone.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_art_timer;
  import art_pkg::*;
  logic clock_i = 1'b0; // 100 mhz core clock
  logic resetn_i = 1'b0; // sync reset, active low
  logic enable_i = 1'b1; // clock enable
  logic base_clock_i = 1'b0; // prescaled base clock pin
  logic [7:0] addr_i = 8'h00; // register address
  logic [15:0] wdata_i = 16'h0000; // write data
  logic write_i = 1'b0; // write strobe
  logic read_i = 1'b0; // read strobe
  logic [15:0] rdata_o; // read data
  logic timer_out_o; // timer output level
  logic irq_o; // interrupt level
  int fails = 0; // mismatch count
  int comparisons = 0; // compare count

  always #5 clock_i = ~clock_i;

  art_timer u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .enable_i(enable_i), .base_clock_i(base_clock_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .timer_out_o(timer_out_o), .irq_o(irq_o));

  // one compare, reported at once on mismatch
  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask

  // one-cycle read; data stand only in the following cycle
  task rd(input logic [7:0] a, input logic [15:0] exp, input string msg);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1;
    chk(rdata_o, exp, msg);
  endtask

  // base clock edges; pin kept slow so the synchroniser sees each one
  task ticks(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clock_i);
      base_clock_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      base_clock_i <= 1'b0;
    end
    repeat (8) @(posedge clock_i);
  endtask

  task t_reset;
    rd(ART_OFF_CONTROL, 16'h0070, "control after reset");
    rd(ART_OFF_IRQ_STATUS, 16'h0000, "status after reset");
    chk({14'h0000, timer_out_o, irq_o}, 16'h0000, "outputs after reset");
    rd(8'h70, 16'h0000, "unmapped read");
    $display("test reset done");
  endtask

  task t_regs;
    wr(ART_OFF_COUNT, 16'hA5C3);
    rd(ART_OFF_COUNT, 16'hA5C3, "count");
    rd(ART_OFF_RELOAD, 16'hA5C3, "reload shadow");
    wr(ART_OFF_RELOAD, 16'h5A3C);
    rd(ART_OFF_RELOAD, 16'h5A3C, "reload");
    rd(ART_OFF_COUNT, 16'hA5C3, "count kept");
    wr(ART_OFF_CONTROL, 16'h00FE);
    rd(ART_OFF_CONTROL, 16'h00FE, "control upper ones");
    wr(ART_OFF_CONTROL, 16'h0000);
    rd(ART_OFF_CONTROL, 16'h0070, "fixed ones");
    enable_i <= 1'b0;
    wr(ART_OFF_COUNT, 16'h1111);
    enable_i <= 1'b1;
    rd(ART_OFF_COUNT, 16'hA5C3, "frozen write ignored");
    $display("test registers done");
  endtask

  // every select code: two divided periods add exactly two, the invalid code none
  task t_select;
    for (int c = 0; c < 8; c++)
    begin
      wr(ART_OFF_COUNT, 16'h1000);
      wr(ART_OFF_CONTROL, 16'h0008 | 16'(c));
      ticks(2 << c);
      wr(ART_OFF_CONTROL, 16'h0000);
      rd(ART_OFF_COUNT, (c == 7) ? 16'h1000 : 16'h1002, "count per select");
    end
    ticks(4);
    rd(ART_OFF_COUNT, 16'h1000, "halted");
    $display("test select done");
  endtask

  task t_overflow;
    wr(ART_OFF_IRQ_ENABLE, 16'h0001);
    wr(ART_OFF_COUNT, 16'hFFFE);
    wr(ART_OFF_RELOAD, 16'h0055);
    wr(ART_OFF_CONTROL, 16'h0088);
    repeat (2) @(posedge clock_i);
    chk({15'h0000, timer_out_o}, 16'h0001, "initial output");
    chk({15'h0000, irq_o}, 16'h0000, "no irq yet");
    ticks(2);
    chk({15'h0000, timer_out_o}, 16'h0000, "output toggled");
    chk({15'h0000, irq_o}, 16'h0001, "irq raised");
    rd(ART_OFF_CONTROL, 16'h0078, "bit7 inverted");
    rd(ART_OFF_COUNT, 16'h0055, "reloaded");
    ticks(1);
    wr(ART_OFF_CONTROL, 16'h0000);
    rd(ART_OFF_COUNT, 16'h0056, "counts on");
    rd(ART_OFF_IRQ_STATUS, 16'h0001, "status sticky");
    wr(ART_OFF_IRQ_ENABLE, 16'h0000);
    repeat (2) @(posedge clock_i);
    chk({15'h0000, irq_o}, 16'h0000, "masked");
    wr(ART_OFF_IRQ_ENABLE, 16'h0001);
    repeat (2) @(posedge clock_i);
    chk({15'h0000, irq_o}, 16'h0001, "unmasked");
    wr(ART_OFF_IRQ_CLEAR, 16'h0001);
    repeat (2) @(posedge clock_i);
    chk({15'h0000, irq_o}, 16'h0000, "cleared");
    rd(ART_OFF_IRQ_STATUS, 16'h0000, "status cleared");
    $display("test overflow done");
  endtask

  task t_reset_again;
    wr(ART_OFF_CONTROL, 16'h008B);
    rd(ART_OFF_IRQ_ENABLE, 16'h0001, "enable before reset");
    chk({15'h0000, timer_out_o}, 16'h0001, "output before reset");
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(ART_OFF_CONTROL, 16'h0070, "control after second reset");
    chk({14'h0000, timer_out_o, irq_o}, 16'h0000, "outputs after second reset");
    rd(ART_OFF_IRQ_ENABLE, 16'h0000, "enable after second reset");
    $display("test second reset done");
  endtask

  task wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // bounded run; running out counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge clock_i);
    fails++;
    $display("wrong value at %0t: run did not finish", $time);
    wrap_up();
  end

  initial
  begin
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset();
    t_regs();
    t_select();
    t_overflow();
    t_reset_again();
    wrap_up();
  end
endmodule
`default_nettype wire
